// >>> bmseq_checker.sv
// Checker: timing and output relations of the boost sequencer
`timescale 1ns/1ps
module bmseq_checker
    import bmseq_pkg::*;
#(
    parameter int LINEAR_PHASE_TWO_CYC = 40
)
(
    input logic                   clock,
    input logic                   srst,
    input logic                   mode_select,
    input bmseq_pkg::bmseq_flags_t flags,
    input logic                   started,
    input bmseq_pkg::bmseq_state_t state,
    input bmseq_pkg::bmseq_ctrl_t  ctrl
);
    import bmseq_pkg::*;
    localparam int L2 = LINEAR_PHASE_TWO_CYC;
    logic run_ok;
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    assign run_ok = flags.input_ok && !flags.over_temp;

    AST_UV: assert property (!flags.input_ok |=> state == FAULT_STATE)
        else $error("undervoltage did not fault");
    AST_LINEAR_PHASE_ONE_SS: assert property (state == LINEAR_PHASE_ONE && mode_select
        && run_ok && flags.out_near_in |=> state == SOFT_START)
        else $error("phase one did not reach soft-start");
    AST_SS_HALF: assert property (state == SOFT_START
        |-> ctrl.switch_en && ctrl.half_limit)
        else $error("soft-start not switching at half limit");
    AST_SS_BST: assert property (state == SOFT_START && run_ok
        && flags.out_at_target |=> state == BOOST_RUN_STATE && started)
        else $error("soft-start did not reach boost");
    AST_FORCED: assert property (state == BOOST_RUN_STATE && run_ok
        && !mode_select && !flags.cur_limit
        |=> state == PASS_THROUGH_STATE && ctrl.forced_pass)
        else $error("low mode pin did not force pass-through");
    AST_NO_FORCE: assert property (!started |-> !ctrl.forced_pass)
        else $error("forced pass-through before startup");
    AST_FAULT_OFF: assert property (state == FAULT_STATE |-> ctrl.fault
        && !ctrl.switch_en && !ctrl.pass_linear && !ctrl.pass_full)
        else $error("fault state left a path on");
    AST_LINEAR_PHASE_TWO_TMO: assert property ($rose(state == LINEAR_PHASE_TWO)
        |-> ##[1:L2] state != LINEAR_PHASE_TWO)
        else $error("phase two outlived its timeout");
    AST_THERMAL: assert property (flags.input_ok && flags.over_temp
        |=> state == THERMAL_STATE && ctrl.fault)
        else $error("over-temperature did not shut down");
    AST_PT_DROP: assert property (state == PASS_THROUGH_STATE
        && mode_select && started && run_ok && flags.drop_high
        |=> state == FAULT_STATE)
        else $error("drop in pass-through did not fault");
    AST_PT_SOFT: assert property ($rose(state == PASS_THROUGH_STATE)
        |-> ctrl.pass_linear && !ctrl.pass_full)
        else $error("pass switch not linear on entry");
endmodule

// >>> bmseq_ctl_model.sv
// Model: system controller that drives the mode pin
`timescale 1ns/1ps
module bmseq_ctl_model #(
    parameter int HOLD = 8
)
(
    input logic  clock,
    input logic  srst,
    input logic  want_low,
    output logic mode_select
);
    int held;
    always_ff @(posedge clock)
        if (srst)
            held <= 0;
        else if (held < HOLD)
            held <= held + 1;
    assign mode_select = !(want_low && held >= HOLD);
endmodule

// >>> bmseq_pkg.sv
// Package: state, flag carriers and timing constants of the boost sequencer
package bmseq_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ         = 250;
    localparam int LINEAR_PHASE_ONE_TMO_US     = 512;
    localparam int LINEAR_PHASE_TWO_TMO_US     = 1024;
    localparam int SS_TMO_US       = 64;
    localparam int PT_IDLE_US      = 5;
    localparam int PT_SOFT_US      = 5;
    localparam int OVL_TMO_MS      = 2;
    localparam int RESTART_MS      = 20;
    localparam int LINEAR_PHASE_ONE_TMO_CYC    = LINEAR_PHASE_ONE_TMO_US * CLK_MHZ;
    localparam int LINEAR_PHASE_TWO_TMO_CYC    = LINEAR_PHASE_TWO_TMO_US * CLK_MHZ;
    localparam int SS_TMO_CYC      = SS_TMO_US * CLK_MHZ;
    localparam int PT_IDLE_CYC     = PT_IDLE_US * CLK_MHZ;
    localparam int PT_SOFT_CYC     = PT_SOFT_US * CLK_MHZ;
    localparam int OVL_TMO_CYC     = OVL_TMO_MS * 1000 * CLK_MHZ;
    localparam int RESTART_CYC     = RESTART_MS * 1000 * CLK_MHZ;
    localparam int CNT_W           = 23;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        LINEAR_PHASE_ONE,
        LINEAR_PHASE_TWO,
        SOFT_START,
        BOOST_RUN_STATE,
        PASS_THROUGH_STATE,
        FAULT_STATE,
        THERMAL_STATE
    } bmseq_state_t;

    // Analog comparator flags
    typedef struct packed {
        logic input_ok;       // input_rail above undervoltage_threshold
        logic out_near_in;    // output_rail within 300 mV of input_rail
        logic out_at_target;  // output_rail at target
        logic in_above_out;   // input_rail above output_rail
        logic drop_high;      // input-to-output drop above 300 mV
        logic cur_limit;      // boost current limit active
        logic over_temp;      // die hot, hysteresis in comparator
        logic sw_pulse;       // a switching pulse occurred
    } bmseq_flags_t;

    // Power stage controls
    typedef struct packed {
        logic precharge_lo;   // linear source, first step
        logic precharge_hi;   // linear source, raised step
        logic switch_en;      // boost modulator running
        logic half_limit;     // current limit at 50 percent
        logic pass_linear;    // input_pass_switch as current source
        logic pass_full;      // input_pass_switch fully enhanced
        logic forced_pass;    // pass-through forced by mode pin
        logic fault;          // fault or thermal shutdown
    } bmseq_ctrl_t;

endpackage

// >>> bmseq_top.sv
// Module: mode sequencer of a fixed-output boost regulator
`timescale 1ns/1ps
module bmseq_top
    import bmseq_pkg::*;
#(
    parameter int LINEAR_PHASE_ONE_CYC    = LINEAR_PHASE_ONE_TMO_CYC,
    parameter int LINEAR_PHASE_TWO_CYC    = LINEAR_PHASE_TWO_TMO_CYC,
    parameter int SS_CYC      = SS_TMO_CYC,
    parameter int PT_IDLE     = PT_IDLE_CYC,
    parameter int PT_SOFT     = PT_SOFT_CYC,
    parameter int OVL_CYC     = OVL_TMO_CYC,
    parameter int RESTART_CNT = RESTART_CYC
)
(
    input  wire logic               clock,
    input  wire logic               srst,
    input  wire logic               mode_select,
    input  wire bmseq_pkg::bmseq_flags_t flags,
    output logic                    started,
    output bmseq_pkg::bmseq_state_t state,
    output bmseq_pkg::bmseq_ctrl_t  ctrl
);
    import bmseq_pkg::*;

    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    // Each count must last a cycle and fit the shared counters
    if (LINEAR_PHASE_ONE_CYC < 1 || LINEAR_PHASE_ONE_CYC >= (1 << CNT_W))
    begin : g_bad_linear_phase_one
        $error("bmseq_top: LINEAR_PHASE_ONE_CYC out of range");
    end

    if (LINEAR_PHASE_TWO_CYC < 1 || LINEAR_PHASE_TWO_CYC >= (1 << CNT_W))
    begin : g_bad_linear_phase_two
        $error("bmseq_top: LINEAR_PHASE_TWO_CYC out of range");
    end

    if (SS_CYC < 1 || SS_CYC >= (1 << CNT_W))
    begin : g_bad_ss
        $error("bmseq_top: SS_CYC out of range");
    end

    if (PT_IDLE < 1 || PT_IDLE >= (1 << CNT_W))
    begin : g_bad_idle
        $error("bmseq_top: PT_IDLE out of range");
    end

    // Soft window is compared one count past its end
    if (PT_SOFT < 1 || PT_SOFT >= (1 << CNT_W) - 1)
    begin : g_bad_soft
        $error("bmseq_top: PT_SOFT out of range");
    end

    if (OVL_CYC < 1 || OVL_CYC >= (1 << CNT_W))
    begin : g_bad_ovl
        $error("bmseq_top: OVL_CYC out of range");
    end

    if (RESTART_CNT < 1 || RESTART_CNT >= (1 << CNT_W))
    begin : g_bad_restart
        $error("bmseq_top: RESTART_CNT out of range");
    end

    // ****************************************************************
    // State record
    // ****************************************************************
    typedef struct packed {
        bmseq_state_t        st;
        logic [CNT_W-1:0]    phase_cnt;  // phase timeout / restart
        logic [CNT_W-1:0]    ovl_cnt;    // continuous current limit
        logic [CNT_W-1:0]    idle_cnt;   // cycles since last pulse
        logic                started;    // a boost startup completed
        bmseq_ctrl_t         ctrl;
    } bmseq_reg_t;

    bmseq_reg_t reg_ff;
    bmseq_reg_t nxt_reg;

    // ****************************************************************
    // Drop fault arming
    // ****************************************************************
    // armed after startup while mode_select is high
    logic drop_armed;
    assign drop_armed = reg_ff.started && mode_select;

    localparam bmseq_reg_t RESET_REG = '{
        st:        LINEAR_PHASE_ONE,
        phase_cnt: '0,
        ovl_cnt:   '0,
        idle_cnt:  '0,
        started:   1'b0,
        ctrl:      '0
    };

    // ****************************************************************
    // Counter helpers
    // ****************************************************************
    function automatic logic reached(input logic [CNT_W-1:0] cnt,
                                     input int lim);
        reached = (cnt >= CNT_W'(lim - 1));
    endfunction

    function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c);
        bump = (&c) ? c : c + CNT_W'(1);
    endfunction

    // Stage controls decoded from the state they accompany
    function automatic bmseq_ctrl_t stage_ctrl(
        input bmseq_state_t     st,
        input logic [CNT_W-1:0] cnt,
        input logic             up,
        input logic             mode);
        stage_ctrl = '0;
        unique case (st)
            LINEAR_PHASE_ONE:
            begin
                stage_ctrl.precharge_lo = mode;
            end
            LINEAR_PHASE_TWO:
            begin
                stage_ctrl.precharge_hi = 1'b1;
            end
            SOFT_START:
            begin
                stage_ctrl.switch_en = 1'b1;
                stage_ctrl.half_limit = 1'b1;
            end
            BOOST_RUN_STATE:
            begin
                stage_ctrl.switch_en = 1'b1;
            end
            PASS_THROUGH_STATE:
            begin
                // soft pass-switch entry
                // Linear while the count runs 0 to PT_SOFT-1
                stage_ctrl.pass_full = reached(cnt, PT_SOFT + 1);
                stage_ctrl.pass_linear = !reached(cnt, PT_SOFT + 1);
                stage_ctrl.forced_pass = !mode && up;
            end
            FAULT_STATE, THERMAL_STATE:
            begin
                stage_ctrl.fault = 1'b1;
            end
        endcase
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        nxt_reg = reg_ff;
        nxt_reg.phase_cnt = bump(reg_ff.phase_cnt);
        // Idle timer restarts on every switching pulse
        nxt_reg.idle_cnt = flags.sw_pulse ? '0 : bump(reg_ff.idle_cnt);
        // Overload time only accrues in boost
        nxt_reg.ovl_cnt = (flags.cur_limit && reg_ff.st == BOOST_RUN_STATE)
                          ? bump(reg_ff.ovl_cnt) : '0;

        unique case (reg_ff.st)
            LINEAR_PHASE_ONE:
            begin
                if (!mode_select)
                begin
                    nxt_reg.phase_cnt = '0;
                end
                else if (flags.out_near_in)
                begin
                    nxt_reg.st = SOFT_START;
                    nxt_reg.phase_cnt = '0;
                end
                else if (reached(reg_ff.phase_cnt, LINEAR_PHASE_ONE_CYC))
                begin
                    nxt_reg.st = LINEAR_PHASE_TWO;
                    nxt_reg.phase_cnt = '0;
                end
            end
            LINEAR_PHASE_TWO:
            begin
                if (flags.out_near_in)
                begin
                    nxt_reg.st = SOFT_START;
                    nxt_reg.phase_cnt = '0;
                end
                else if (reached(reg_ff.phase_cnt, LINEAR_PHASE_TWO_CYC))
                begin
                    nxt_reg.st = FAULT_STATE;
                    nxt_reg.phase_cnt = '0;
                end
            end
            SOFT_START:
            begin
                if (flags.out_at_target)
                begin
                    nxt_reg.st = BOOST_RUN_STATE;
                    nxt_reg.started = 1'b1;
                    nxt_reg.phase_cnt = '0;
                end
                else if (reached(reg_ff.phase_cnt, SS_CYC))
                begin
                    nxt_reg.st = FAULT_STATE;
                    nxt_reg.phase_cnt = '0;
                end
            end
            BOOST_RUN_STATE:
            begin
                if (flags.cur_limit && reached(reg_ff.ovl_cnt, OVL_CYC))
                begin
                    nxt_reg.st = FAULT_STATE;
                    nxt_reg.phase_cnt = '0;
                end
                else if (!mode_select)
                begin
                    nxt_reg.st = PASS_THROUGH_STATE;
                    nxt_reg.phase_cnt = '0;
                end
                else if (flags.in_above_out && !flags.sw_pulse &&
                         reached(reg_ff.idle_cnt, PT_IDLE))
                begin
                    nxt_reg.st = PASS_THROUGH_STATE;
                    nxt_reg.phase_cnt = '0;
                end
            end
            PASS_THROUGH_STATE:
            begin
                if (drop_armed && flags.drop_high)
                begin
                    nxt_reg.st = FAULT_STATE;
                    nxt_reg.phase_cnt = '0;
                end
                else if (mode_select && !flags.in_above_out &&
                         flags.out_at_target)
                begin
                    nxt_reg.st = BOOST_RUN_STATE;
                    nxt_reg.phase_cnt = '0;
                end
            end
            FAULT_STATE:
            begin
                if (reached(reg_ff.phase_cnt, RESTART_CNT))
                begin
                    nxt_reg.st = LINEAR_PHASE_ONE;
                    nxt_reg.started = 1'b0;
                    nxt_reg.phase_cnt = '0;
                end
            end
            THERMAL_STATE:
            begin
                nxt_reg.phase_cnt = '0;
                if (!flags.over_temp)
                begin
                    nxt_reg.st = LINEAR_PHASE_ONE;
                end
            end
        endcase

        if (flags.over_temp && reg_ff.st != THERMAL_STATE)
        begin
            nxt_reg.st = THERMAL_STATE;
            nxt_reg.started = 1'b0;
            nxt_reg.phase_cnt = '0;
        end

        if (!flags.input_ok)
        begin
            nxt_reg = RESET_REG;
            nxt_reg.st = FAULT_STATE;
        end

        // Stage controls follow the next state
        nxt_reg.ctrl = stage_ctrl(nxt_reg.st, nxt_reg.phase_cnt,
                                  nxt_reg.started, mode_select);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            reg_ff <= RESET_REG;
        end
        else
        begin
            reg_ff <= nxt_reg;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign started = reg_ff.started;
    assign state   = reg_ff.st;
    assign ctrl    = reg_ff.ctrl;

endmodule

// >>> tb_top.sv
// Testbench: scenario tasks for the boost sequencer
`timescale 1ns/1ps
module tb_top;
    import bmseq_pkg::*;
    localparam int L1 = 20, L2 = 40, SS = 10, PI = 4, PS = 4;
    localparam int OV = 30, RS = 50;
    logic         clock = 0, srst = 1, want_low = 0, mode_select, started;
    bmseq_flags_t fl = '0;
    bmseq_state_t state;
    bmseq_ctrl_t  ctrl;
    int           mismatches = 0, samples_checked = 0, n;
    always #2 clock = ~clock;
    bmseq_ctl_model #(.HOLD(8)) ctl (.clock(clock), .srst(srst),
        .want_low(want_low), .mode_select(mode_select));
    bmseq_top #(.LINEAR_PHASE_ONE_CYC(L1), .LINEAR_PHASE_TWO_CYC(L2), .SS_CYC(SS), .PT_IDLE(PI),
        .PT_SOFT(PS), .OVL_CYC(OV), .RESTART_CNT(RS)) DUT (.clock(clock),
        .srst(srst), .mode_select(mode_select), .flags(fl),
        .started(started), .state(state), .ctrl(ctrl));
    // ********
    // Helpers
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %0h vs %0h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clock);
    endtask
    task automatic wait_st(input bmseq_state_t s, input int lim);
        n = 0;
        while (state !== s && n < lim)
        begin
            @(negedge clock);
            n++;
        end
        chk(state, s);
    endtask
    task automatic restart_dut();
        fl = '0;
        fl.input_ok = 1;
        want_low = 0;
        srst = 1;
        cyc(8);
        srst = 0;
    endtask
    task automatic to_boost();
        restart_dut();
        cyc(2);
        chk(ctrl.precharge_lo, 1'h1);
        fl.out_near_in = 1;
        cyc(1);
        chk(state, SOFT_START);
        chk(ctrl.switch_en & ctrl.half_limit, 1'h1);
        fl.out_at_target = 1;
        cyc(1);
        chk(state, BOOST_RUN_STATE);
        fl.out_near_in = 0;
        fl.out_at_target = 0;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_timeouts();
        restart_dut();
        wait_st(LINEAR_PHASE_TWO, L1 + 3);
        chk(ctrl.precharge_hi, 1'h1);
        wait_st(FAULT_STATE, L2 + 3);
        chk(n, L2);
        chk(ctrl, 8'h01);
        wait_st(LINEAR_PHASE_ONE, RS + 3);
        chk(n, RS);
        fl.out_near_in = 1;
        wait_st(SOFT_START, 3);
        wait_st(FAULT_STATE, SS + 3);
        chk(n, SS);
        $display("test timeouts done");
    endtask
    task automatic t_forced();
        restart_dut();
        want_low = 1;
        cyc(L1 + 10);
        chk(state, LINEAR_PHASE_ONE);
        to_boost();
        cyc(8);
        want_low = 1;
        cyc(1);
        chk(ctrl.forced_pass & ctrl.pass_linear, 1'h1);
        cyc(PS - 1);
        chk(ctrl.pass_linear, 1'h1);
        fl.drop_high = 1;
        cyc(1);
        chk(ctrl.pass_full, 1'h1);
        chk(state, PASS_THROUGH_STATE);
        fl.drop_high = 0;
        want_low = 0;
        fl.out_at_target = 1;
        cyc(1);
        chk(state, BOOST_RUN_STATE);
        $display("test forced done");
    endtask
    task automatic t_auto();
        to_boost();
        fl.in_above_out = 1;
        fl.sw_pulse = 1;
        cyc(1);
        fl.sw_pulse = 0;
        wait_st(PASS_THROUGH_STATE, PI + 3);
        chk(n, PI);
        fl.in_above_out = 0;
        fl.out_at_target = 1;
        cyc(1);
        chk(state, BOOST_RUN_STATE);
        fl.out_at_target = 0;
        fl.in_above_out = 1;
        wait_st(PASS_THROUGH_STATE, PI + 3);
        fl.drop_high = 1;
        cyc(1);
        chk(state, FAULT_STATE);
        $display("test auto done");
    endtask
    task automatic t_protect();
        to_boost();
        fl.cur_limit = 1;
        wait_st(FAULT_STATE, OV + 3);
        chk(n, OV);
        to_boost();
        fl.over_temp = 1;
        cyc(1);
        chk(state, THERMAL_STATE);
        chk(ctrl.fault, 1'h1);
        fl.over_temp = 0;
        cyc(1);
        chk(state, LINEAR_PHASE_ONE);
        fl.input_ok = 0;
        cyc(RS + 5);
        chk(state, FAULT_STATE);
        chk(started, 1'h0);
        fl.input_ok = 1;
        wait_st(LINEAR_PHASE_ONE, RS + 3);
        chk(n, RS);
        $display("test protect done");
    endtask
    initial
    begin
        t_timeouts();
        t_forced();
        t_auto();
        t_protect();
        print_verdict();
    end
    initial
    begin
        repeat (4000) @(posedge clock);
        mismatches++;
        print_verdict();
    end
endmodule
bind bmseq_top bmseq_checker #(.LINEAR_PHASE_TWO_CYC(LINEAR_PHASE_TWO_CYC)) u_chk (.clock(clock),
    .srst(srst), .mode_select(mode_select), .flags(flags),
    .started(started), .state(state), .ctrl(ctrl));
